// >>> src/rag_addr_gen.sv
// ram/rom address generator: pc update, ram address, rom table fetch
// Function
// - indirect ram address from w, x, y
// - direct access: second word is address
// - 16-word window from window instructions; indirect and direct addresses also reach it
// - long jumps and full-range calls load all 14 bits
// - rom is 64 pages of 256 words
// - in-page jump replaces low eight bits
// - last-word in-page jump lands next page
// - zero-page call: six bits, upper cleared
// - table jump from immediate, acc, companion
// - fetch flag bit 8 writes accumulator pair
// - fetch flag bit 9 writes both ports
// - both flags write both destinations
// - table fetch never branches
// - rom words are ten bits wide
`timescale 1ns/1ps
`default_nettype none
module rag_addr_gen
  import rag_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  // decoded instruction
  input  wire logic        OP_VALID,
  input  wire rag_op_e     OP_CODE,
  input  wire logic [13:0] OP_IMM,
  // second instruction word
  input  wire logic        WORD_VALID,
  input  wire logic [9:0]  WORD_IN,
  // core registers
  input  wire logic [1:0]  IDX_W,
  input  wire logic [3:0]  IDX_X,
  input  wire logic [3:0]  IDX_Y,
  input  wire logic [3:0]  ACC_IN,
  input  wire logic [3:0]  BREG_IN,
  // rom table data
  input  wire logic        ROM_DATA_VALID,
  input  wire logic [9:0]  ROM_DATA,
  // program counter
  output logic      [13:0] PC,
  output logic             BUSY,
  // ram address
  output logic      [9:0]  RAM_ADDR,
  output logic             RAM_REQ,
  // rom table address
  output logic      [13:0] ROM_ADDR,
  output logic             ROM_REQ,
  // accumulator pair write
  output logic      [3:0]  ACC_OUT,
  output logic      [3:0]  BREG_OUT,
  output logic             ACC_WE,
  // port output registers
  output logic      [3:0]  PORT_OUT_ONE,
  output logic      [3:0]  PORT_OUT_TWO,
  output logic             PORT_WE
);

  // state registers and next values
  rag_state_e  state_r, state_nxt;      // sequencer
  logic [13:0] pc_r, pc_nxt;            // program counter
  logic        busy_r, busy_nxt;        // multi-cycle op pending
  logic [9:0]  ram_addr_r, ram_addr_nxt;
  logic        ram_req_r, ram_req_nxt;
  logic [13:0] rom_addr_r, rom_addr_nxt;
  logic        rom_req_r, rom_req_nxt;
  logic [3:0]  acc_r, acc_nxt;          // accumulator value
  logic [3:0]  breg_r, breg_nxt;        // companion value
  logic        acc_we_r, acc_we_nxt;
  logic [3:0]  p1_r, p1_nxt;            // port_out_one
  logic [3:0]  p2_r, p2_nxt;            // port_out_two
  logic        port_we_r, port_we_nxt;

  // combinational helpers
  logic [13:0] pc_inc;                  // pc plus one
  logic [13:0] tbl_addr;                // table address
  logic [13:0] target;                  // pc after this op
  logic        is_branch;               // op loads the pc
  logic [9:0]  ram_addr_c;              // single-word ram address
  logic        ram_req_c;               // op accesses ram
  logic        take;                    // instruction accepted
  logic        tbl_done;                // rom data arrived
  logic [7:0]  rom_byte;                // data part of rom word

  assign take     = OP_VALID && (state_r == RAG_S_IDLE);
  assign tbl_done = ROM_DATA_VALID && (state_r == RAG_S_TBL);
  assign rom_byte = ROM_DATA[7:0];

  // pc target
  rag_pc_calc u_pc_calc (
    .pc        (pc_r),
    .op        (OP_CODE),
    .imm       (OP_IMM),
    .acc       (ACC_IN),
    .breg      (BREG_IN),
    .pc_inc    (pc_inc),
    .tbl_addr  (tbl_addr),
    .target    (target),
    .is_branch (is_branch)
  );

  // ram address for one-word modes
  rag_ram_calc u_ram_calc (
    .op      (OP_CODE),
    .idx_w   (IDX_W),
    .idx_x   (IDX_X),
    .idx_y   (IDX_Y),
    .win_sel (OP_IMM[3:0]),
    .addr    (ram_addr_c),
    .req     (ram_req_c)
  );

  // next-state logic for the whole block
  always_comb begin
    state_nxt    = state_r;
    pc_nxt       = pc_r;
    ram_addr_nxt = ram_addr_r;
    ram_req_nxt  = 1'b0;
    rom_addr_nxt = rom_addr_r;
    rom_req_nxt  = 1'b0;
    acc_nxt      = acc_r;
    breg_nxt     = breg_r;
    acc_we_nxt   = 1'b0;
    p1_nxt       = p1_r;
    p2_nxt       = p2_r;
    port_we_nxt  = 1'b0;
    case (state_r)
      RAG_S_IDLE: begin
        if (OP_VALID) begin
          // branch target or plain advance
          pc_nxt = is_branch ? target : pc_inc;
          if (ram_req_c) begin
            ram_addr_nxt = ram_addr_c;
            ram_req_nxt  = 1'b1;
          end
          if (OP_CODE == RAG_OP_RAM_DIR) begin
            state_nxt = RAG_S_DIR2;
          end
          if (OP_CODE == RAG_OP_TABLE_FETCH) begin
            // fetch address, pc only advances
            rom_addr_nxt = tbl_addr;
            rom_req_nxt  = 1'b1;
            state_nxt    = RAG_S_TBL;
          end
        end
      end
      RAG_S_DIR2: begin
        if (WORD_VALID) begin
          // whole second word is the address
          ram_addr_nxt = WORD_IN;
          ram_req_nxt  = 1'b1;
          pc_nxt       = pc_inc;
          state_nxt    = RAG_S_IDLE;
        end
      end
      RAG_S_TBL: begin
        if (ROM_DATA_VALID) begin
          // ten-bit word: two flags above the data byte
          if (ROM_DATA[RAG_FLAG_ACC]) begin
            acc_nxt    = ROM_DATA[RAG_LO_NIB +: RAG_NIB_W];
            breg_nxt   = ROM_DATA[RAG_HI_NIB +: RAG_NIB_W];
            acc_we_nxt = 1'b1;
          end
          // independent test, so both may fire
          if (ROM_DATA[RAG_FLAG_PORT]) begin
            p1_nxt      = ROM_DATA[RAG_LO_NIB +: RAG_NIB_W];
            p2_nxt      = ROM_DATA[RAG_HI_NIB +: RAG_NIB_W];
            port_we_nxt = 1'b1;
          end
          state_nxt = RAG_S_IDLE;
        end
      end
      default: begin
        state_nxt = RAG_S_IDLE;
      end
    endcase
    busy_nxt = (state_nxt != RAG_S_IDLE);
  end

  // register stage
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r    <= RAG_S_IDLE;
      pc_r       <= RAG_PC_RST;
      busy_r     <= 1'b0;
      ram_addr_r <= RAG_RAM_RST;
      ram_req_r  <= 1'b0;
      rom_addr_r <= RAG_PC_RST;
      rom_req_r  <= 1'b0;
      acc_r      <= RAG_NIB_RST;
      breg_r     <= RAG_NIB_RST;
      acc_we_r   <= 1'b0;
      p1_r       <= RAG_NIB_RST;
      p2_r       <= RAG_NIB_RST;
      port_we_r  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      pc_r       <= pc_nxt;
      busy_r     <= busy_nxt;
      ram_addr_r <= ram_addr_nxt;
      ram_req_r  <= ram_req_nxt;
      rom_addr_r <= rom_addr_nxt;
      rom_req_r  <= rom_req_nxt;
      acc_r      <= acc_nxt;
      breg_r     <= breg_nxt;
      acc_we_r   <= acc_we_nxt;
      p1_r       <= p1_nxt;
      p2_r       <= p2_nxt;
      port_we_r  <= port_we_nxt;
    end
  end

  // outputs straight from flops
  assign PC           = pc_r;
  assign BUSY         = busy_r;
  assign RAM_ADDR     = ram_addr_r;
  assign RAM_REQ      = ram_req_r;
  assign ROM_ADDR     = rom_addr_r;
  assign ROM_REQ      = rom_req_r;
  assign ACC_OUT      = acc_r;
  assign BREG_OUT     = breg_r;
  assign ACC_WE       = acc_we_r;
  assign PORT_OUT_ONE = p1_r;
  assign PORT_OUT_TWO = p2_r;
  assign PORT_WE      = port_we_r;

  // assertion helpers
  logic [9:0]  idx_cat;                 // joined index registers
  logic [7:0]  imm_lo8;                 // in-page immediate
  logic [5:0]  imm_zp;                  // zero-page immediate
  logic [5:0]  pc_page;                 // current page number
  logic        pc_last;                 // pc at last word of page
  assign idx_cat = {IDX_W, IDX_X, IDX_Y};
  assign imm_lo8 = OP_IMM[7:0];
  assign imm_zp  = OP_IMM[5:0];
  assign pc_page = pc_r[13:8];
  assign pc_last = (pc_r[7:0] == 8'hFF);

  property p_ind;
    @(posedge CORE_CLK) disable iff (!RSTN)
    take && OP_CODE == RAG_OP_RAM_IND |=> RAM_REQ && RAM_ADDR == $past(idx_cat);
  endproperty
  a_ind: assert property (p_ind) else $error("indirect ram address wrong");

  property p_dir;
    @(posedge CORE_CLK) disable iff (!RSTN)
    take && OP_CODE == RAG_OP_RAM_DIR ##1 WORD_VALID
      |=> RAM_REQ && RAM_ADDR == $past(WORD_IN) && !BUSY;
  endproperty
  a_dir: assert property (p_dir) else $error("direct ram address wrong");

  property p_win;
    @(posedge CORE_CLK) disable iff (!RSTN)
    RAM_REQ && !$past(state_r == RAG_S_DIR2) && RAM_ADDR[9:4] == RAG_WIN_BASE_HI
      |-> $past(OP_CODE) == RAG_OP_LOAD_WIN || $past(OP_CODE) == RAG_OP_SWAP_WIN
          || $past(OP_CODE) == RAG_OP_RAM_IND;
  endproperty
  a_win: assert property (p_win) else $error("window reached by wrong op");

  property p_long;
    @(posedge CORE_CLK) disable iff (!RSTN)
    take && (OP_CODE == RAG_OP_LONG_GOTO || OP_CODE == RAG_OP_FAR_GOTO
             || OP_CODE == RAG_OP_CALL)
      |=> PC == $past(OP_IMM);
  endproperty
  a_long: assert property (p_long) else $error("long jump target wrong");

  property p_page;
    @(posedge CORE_CLK) disable iff (!RSTN)
    take && OP_CODE == RAG_OP_IN_PAGE && !pc_last
      |=> PC[7:0] == $past(imm_lo8) && PC[13:8] == $past(pc_page);
  endproperty
  a_page: assert property (p_page) else $error("in-page jump wrong");

  property p_edge;
    @(posedge CORE_CLK) disable iff (!RSTN)
    take && OP_CODE == RAG_OP_IN_PAGE && pc_last
      |=> PC[13:8] == 6'($past(pc_page) + 6'h01);
  endproperty
  a_edge: assert property (p_edge) else $error("page edge jump wrong");

  property p_zcall;
    @(posedge CORE_CLK) disable iff (!RSTN)
    take && OP_CODE == RAG_OP_ZCALL |=> PC[13:6] == 8'h00 && PC[5:0] == $past(imm_zp);
  endproperty
  a_zcall: assert property (p_zcall) else $error("zero-page call wrong");

  property p_tjump;
    @(posedge CORE_CLK) disable iff (!RSTN)
    take && OP_CODE == RAG_OP_TABLE_JUMP |=> PC == $past(tbl_addr);
  endproperty
  a_tjump: assert property (p_tjump) else $error("table jump target wrong");

  property p_acc;
    @(posedge CORE_CLK) disable iff (!RSTN)
    tbl_done |=> ACC_WE == $past(ROM_DATA[8]) && (!$past(ROM_DATA[8]) ||
      {BREG_OUT, ACC_OUT} == $past(rom_byte));
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator pair write wrong");

  property p_port;
    @(posedge CORE_CLK) disable iff (!RSTN)
    tbl_done |=> PORT_WE == $past(ROM_DATA[9]) && (!$past(ROM_DATA[9]) ||
      {PORT_OUT_TWO, PORT_OUT_ONE} == $past(rom_byte));
  endproperty
  a_port: assert property (p_port) else $error("port write wrong");

  property p_both;
    @(posedge CORE_CLK) disable iff (!RSTN)
    tbl_done && ROM_DATA[9:8] == 2'h3 |=> ACC_WE && PORT_WE;
  endproperty
  a_both: assert property (p_both) else $error("dual write missing");

  property p_fetch;
    @(posedge CORE_CLK) disable iff (!RSTN)
    take && OP_CODE == RAG_OP_TABLE_FETCH
      |=> PC == $past(pc_inc) && ROM_REQ && ROM_ADDR == $past(tbl_addr) && BUSY;
  endproperty
  a_fetch: assert property (p_fetch) else $error("table fetch moved the pc");

  // pc frozen while the table word is awaited
  property p_hold;
    @(posedge CORE_CLK) disable iff (!RSTN)
    state_r == RAG_S_TBL |=> PC == $past(PC);
  endproperty
  a_hold: assert property (p_hold) else $error("pc moved during table fetch");

  property p_seq;
    @(posedge CORE_CLK) disable iff (!RSTN)
    take && OP_CODE == RAG_OP_SEQ |=> PC == $past(pc_inc);
  endproperty
  a_seq: assert property (p_seq) else $error("sequential advance wrong");

endmodule : rag_addr_gen
`default_nettype wire

// >>> src/rag_pc_calc.sv
// next program counter calculation
`timescale 1ns/1ps
`default_nettype none
module rag_pc_calc
  import rag_pkg::*;
(
  // current state
  input  wire logic [13:0] pc,
  input  wire rag_op_e     op,
  // operands
  input  wire logic [13:0] imm,
  input  wire logic [3:0]  acc,
  input  wire logic [3:0]  breg,
  // results
  output logic      [13:0] pc_inc,
  output logic      [13:0] tbl_addr,
  output logic      [13:0] target,
  output logic             is_branch
);

  // sequential advance and table address
  always_comb begin
    pc_inc    = 14'(pc + 14'h0001);
    tbl_addr  = {RAG_TBL_HI, imm[3:0], breg, acc};
    target    = pc_inc;
    is_branch = 1'b0;
    case (op)
      RAG_OP_LONG_GOTO, RAG_OP_FAR_GOTO, RAG_OP_CALL: begin
        target    = imm;
        is_branch = 1'b1;
      end
      RAG_OP_IN_PAGE: begin
        // page taken from the already advanced pc
        target    = {pc_inc[13:RAG_PAGE_LSB], imm[7:0]};
        is_branch = 1'b1;
      end
      RAG_OP_ZCALL: begin
        target    = {8'h00, imm[RAG_ZP_W-1:0]};
        is_branch = 1'b1;
      end
      RAG_OP_TABLE_JUMP: begin
        target    = tbl_addr;
        is_branch = 1'b1;
      end
      default: begin
        // no branch, table fetch included
        target    = pc_inc;
        is_branch = 1'b0;
      end
    endcase
  end

endmodule : rag_pc_calc
`default_nettype wire

// >>> src/rag_pkg.sv
// shared constants and types for the ram/rom address generator
package rag_pkg;

  // widths
  localparam int unsigned RAG_PC_W   = 14;            // program counter bits
  localparam int unsigned RAG_RAM_W  = 10;            // ram address bits
  localparam int unsigned RAG_WORD_W = 10;            // rom instruction word bits
  localparam int unsigned RAG_NIB_W  = 4;             // data nibble bits

  // rom word fields during a table fetch
  localparam int unsigned RAG_FLAG_ACC  = 8;          // flag: write accumulator pair
  localparam int unsigned RAG_FLAG_PORT = 9;          // flag: write port output registers
  localparam int unsigned RAG_LO_NIB    = 0;          // low data nibble position
  localparam int unsigned RAG_HI_NIB    = 4;          // high data nibble position

  // memory-register window
  localparam logic [5:0] RAG_WIN_BASE_HI = 6'h04;     // window starts at 0x040
  localparam int unsigned RAG_WIN_SIZE   = 16;        // registers in the window

  // paging and zero page
  localparam int unsigned RAG_PAGE_LSB  = 8;          // first page-number bit of the pc
  localparam int unsigned RAG_PAGES     = 64;         // rom pages
  localparam int unsigned RAG_PAGE_WDS  = 256;        // words per page
  localparam int unsigned RAG_ZP_W      = 6;          // zero-page call immediate bits
  localparam logic [1:0]  RAG_TBL_HI    = 2'h0;       // top bits of table addresses

  // reset values
  localparam logic [13:0] RAG_PC_RST  = 14'h0000;     // pc after reset
  localparam logic [9:0]  RAG_RAM_RST = 10'h000;      // ram address after reset
  localparam logic [3:0]  RAG_NIB_RST = 4'h0;         // data registers after reset

  // decoded operation classes from the instruction decoder
  typedef enum logic [3:0] {
    RAG_OP_SEQ,          // any other instruction word
    RAG_OP_RAM_IND,      // ram access through w/x/y
    RAG_OP_RAM_DIR,      // two-word direct ram access
    RAG_OP_LOAD_WIN,     // load_acc_from_window
    RAG_OP_SWAP_WIN,     // swap_window_with_acc
    RAG_OP_LONG_GOTO,    // long_goto
    RAG_OP_FAR_GOTO,     // far_goto
    RAG_OP_CALL,         // full-range subroutine call
    RAG_OP_IN_PAGE,      // in_page_jump
    RAG_OP_ZCALL,        // zero-page call
    RAG_OP_TABLE_JUMP,   // table_jump
    RAG_OP_TABLE_FETCH   // rom table fetch
  } rag_op_e;

  // sequencer states
  typedef enum logic [1:0] {
    RAG_S_IDLE,          // ready for an instruction
    RAG_S_DIR2,          // waiting for the address word
    RAG_S_TBL            // waiting for rom table data
  } rag_state_e;

endpackage : rag_pkg

// >>> src/rag_ram_calc.sv
// single-word ram address formation
`timescale 1ns/1ps
`default_nettype none
module rag_ram_calc
  import rag_pkg::*;
(
  // operation and operands
  input  wire rag_op_e    op,
  input  wire logic [1:0] idx_w,
  input  wire logic [3:0] idx_x,
  input  wire logic [3:0] idx_y,
  input  wire logic [3:0] win_sel,
  // result
  output logic      [9:0] addr,
  output logic            req
);

  // address mux per mode
  always_comb begin
    addr = RAG_RAM_RST;
    req  = 1'b0;
    case (op)
      RAG_OP_RAM_IND: begin
        addr = {idx_w, idx_x, idx_y};
        req  = 1'b1;
      end
      RAG_OP_LOAD_WIN, RAG_OP_SWAP_WIN: begin
        // these two form a 16-entry window address; indirect and direct can also hit it
        addr = {RAG_WIN_BASE_HI, win_sel};
        req  = 1'b1;
      end
      default: begin
        addr = RAG_RAM_RST;
        req  = 1'b0;
      end
    endcase
  end

endmodule : rag_ram_calc
`default_nettype wire

// >>> tb/rag_rom_model.sv
// behavioural table-data rom answering the address generator's fetches
`timescale 1ns/1ps
`default_nettype none
module rag_rom_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // table request from the generator
  input  wire logic        rom_req,
  input  wire logic [13:0] rom_addr,
  input  wire logic [1:0]  delay,
  // table data back
  output logic             rom_valid,
  output logic      [9:0]  rom_data
);
  logic        pend;    // request still waiting for its word
  logic [13:0] addr_q;  // captured table address
  logic [1:0]  cnt;     // cycles left before answering

  // flags from address bits 9:8, data scrambled from the low byte
  function automatic logic [9:0] word_at(logic [13:0] a);
    return {a[9:8], a[7:0] ^ 8'hA5};
  endfunction : word_at

  // answers just after the falling edge, holds one full cycle
  always @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      pend = 1'b0;
      addr_q = 14'h0000;
      cnt = 2'h0;
      rom_valid <= 1'b0;
      rom_data <= 10'h155;
    end else begin
      // new request: capture address and chosen delay
      if (rom_req) begin
        pend = 1'b1;
        addr_q = rom_addr;
        cnt = delay;
      end
      if (rom_valid) begin
        rom_valid <= 1'b0;
        rom_data <= ~rom_data; // released: never shows a stale word
      end else if (pend && cnt == 2'h0) begin
        rom_valid <= 1'b1;
        rom_data <= word_at(addr_q);
        pend = 1'b0;
      end else begin
        rom_data <= ~rom_data; // changing pattern while idle
        if (pend) cnt = cnt - 2'h1;
      end
    end
  end
endmodule : rag_rom_model
`default_nettype wire

// >>> tb/tb_ram_rom_address_generation.sv
// self-checking random bench for the ram/rom address generator
`timescale 1ns/1ps
`default_nettype none
module tb_ram_rom_address_generation
  import rag_pkg::*;
;
  logic        clk = 1'b0;        // core clock
  logic        rstn = 1'b0;       // async reset, active low
  logic        op_valid = 1'b0;   // instruction offered
  rag_op_e     op_code = RAG_OP_SEQ;
  logic [13:0] op_imm = 14'h0000;
  logic        word_valid = 1'b0; // second word offered
  logic [9:0]  word_in = 10'h000;
  logic [1:0]  idx_w = 2'h0;
  logic [3:0]  idx_x = 4'h0, idx_y = 4'h0, acc = 4'h0, breg = 4'h0;
  logic [1:0]  dly = 2'h0;        // rom answer delay
  logic        rom_valid, busy, ram_req, rom_req, acc_we, port_we;
  logic [9:0]  rom_data, ram_addr;
  logic [13:0] pc, rom_addr;
  logic [3:0]  acc_out, breg_out, p1, p2;
  logic [13:0] e_pc = 14'h0000;   // expected state
  logic [9:0]  e_ram = 10'h000;
  logic [3:0]  e_acc = 4'h0, e_b = 4'h0, e_p1 = 4'h0, e_p2 = 4'h0;
  int          err_total = 0;
  int          total_checks = 0;

  // 50 ns clock
  always #25 clk = ~clk;

  rag_addr_gen u_rag_addr_gen (
    .CORE_CLK(clk), .RSTN(rstn), .OP_VALID(op_valid), .OP_CODE(op_code), .OP_IMM(op_imm),
    .WORD_VALID(word_valid), .WORD_IN(word_in), .IDX_W(idx_w), .IDX_X(idx_x),
    .IDX_Y(idx_y), .ACC_IN(acc), .BREG_IN(breg), .ROM_DATA_VALID(rom_valid),
    .ROM_DATA(rom_data), .PC(pc), .BUSY(busy), .RAM_ADDR(ram_addr), .RAM_REQ(ram_req),
    .ROM_ADDR(rom_addr), .ROM_REQ(rom_req), .ACC_OUT(acc_out), .BREG_OUT(breg_out),
    .ACC_WE(acc_we), .PORT_OUT_ONE(p1), .PORT_OUT_TWO(p2), .PORT_WE(port_we));

  rag_rom_model u_rag_rom_model (
    .clk(clk), .rstn(rstn), .rom_req(rom_req), .rom_addr(rom_addr), .delay(dly),
    .rom_valid(rom_valid), .rom_data(rom_data));

  // expected rom word: bench's own copy of the table contents
  function automatic logic [9:0] rom_word(logic [13:0] a);
    return {a[9:8], a[7:0] ^ 8'hA5};
  endfunction : rom_word

  // compare a value
  task automatic chk_val(string nm, logic [13:0] e, logic [13:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  // compare a flag
  task automatic chk_bit(string nm, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  // counts, verdict, end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  // one instruction, kept on the bus until replaced; busy edges refuse it
  task automatic run_op(rag_op_e c, logic [13:0] imm);
    logic [13:0] t;
    logic [9:0]  w;
    logic        ramq;
    int          n;
    op_valid = 1'b1;
    op_code = c;
    op_imm = imm;
    dly = 2'($urandom);
    idx_w = 2'($urandom);
    idx_x = 4'($urandom);
    idx_y = 4'($urandom);
    acc = 4'($urandom);
    breg = 4'($urandom);
    @(negedge clk);
    ramq = 1'b0;
    e_pc = e_pc + 14'h0001;
    t = {2'h0, imm[3:0], breg, acc};
    case (c)
      RAG_OP_RAM_IND: begin
        ramq = 1'b1;
        e_ram = {idx_w, idx_x, idx_y};
      end
      RAG_OP_LOAD_WIN, RAG_OP_SWAP_WIN: begin
        ramq = 1'b1;
        e_ram = {RAG_WIN_BASE_HI, imm[3:0]};
      end
      RAG_OP_LONG_GOTO, RAG_OP_FAR_GOTO, RAG_OP_CALL: e_pc = imm;
      RAG_OP_IN_PAGE: e_pc = {e_pc[13:8], imm[7:0]};
      RAG_OP_ZCALL: e_pc = {8'h00, imm[5:0]};
      RAG_OP_TABLE_JUMP: e_pc = t;
      default: ;
    endcase
    chk_val("pc", e_pc, pc);
    chk_bit("ram_req", ramq, ram_req);
    chk_val("ram_addr", {4'h0, e_ram}, {4'h0, ram_addr});
    chk_bit("busy", c == RAG_OP_RAM_DIR || c == RAG_OP_TABLE_FETCH, busy);
    if (c == RAG_OP_RAM_DIR) begin
      // opcode stays offered while busy and must be ignored
      repeat (dly) @(negedge clk);
      w = 10'($urandom);
      word_valid = 1'b1;
      word_in = w;
      @(negedge clk);
      word_valid = 1'b0;
      word_in = ~w;
      e_pc = e_pc + 14'h0001;
      e_ram = w;
      chk_bit("dir_req", 1'b1, ram_req);
      chk_val("dir_addr", {4'h0, w}, {4'h0, ram_addr});
      chk_val("dir_pc", e_pc, pc);
      chk_bit("dir_busy", 1'b0, busy);
    end else if (c == RAG_OP_TABLE_FETCH) begin
      w = rom_word(t);
      chk_bit("rom_req", 1'b1, rom_req);
      chk_val("rom_addr", t, rom_addr);
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (busy !== 1'b0 && n < 12);
      if (n >= 12) begin
        err_total++;
        give_verdict();
      end
      if (w[8]) {e_b, e_acc} = w[7:0];
      if (w[9]) {e_p2, e_p1} = w[7:0];
      chk_bit("acc_we", w[8], acc_we);
      chk_bit("port_we", w[9], port_we);
      chk_val("acc_pair", {6'h00, e_b, e_acc}, {6'h00, breg_out, acc_out});
      chk_val("ports", {6'h00, e_p2, e_p1}, {6'h00, p2, p1});
      chk_val("fetch_pc", e_pc, pc);
    end else begin
      chk_bit("we_idle", 1'b0, acc_we | port_we);
      chk_bit("rom_idle", 1'b0, rom_req);
    end
  endtask : run_op

  // hang guard
  initial begin
    #2000000;
    err_total++;
    give_verdict();
  end

  // main sequence
  initial begin
    void'($urandom(32'h2d56));
    repeat (3) @(negedge clk);
    chk_val("rst_pc", 14'h0000, pc);
    chk_bit("rst_busy", 1'b0, busy);
    rstn = 1'b1;
    @(negedge clk);
    // last word of a page, and of the whole rom
    run_op(RAG_OP_LONG_GOTO, 14'h01FF);
    run_op(RAG_OP_IN_PAGE, 14'h3F12);
    run_op(RAG_OP_FAR_GOTO, 14'h3FFF);
    run_op(RAG_OP_IN_PAGE, 14'h00AB);
    run_op(RAG_OP_CALL, 14'h2A5C);
    run_op(RAG_OP_ZCALL, 14'h3FFF);
    // every flag code, fetches back to back
    for (int k = 0; k < 4; k++) run_op(RAG_OP_TABLE_FETCH, 14'(k));
    run_op(RAG_OP_RAM_DIR, 14'h0000);
    run_op(RAG_OP_RAM_DIR, 14'h0000);
    repeat (400) run_op(rag_op_e'(4'($urandom_range(0, 11))), 14'($urandom));
    // reset in mid-run
    rstn = 1'b0;
    @(negedge clk);
    chk_val("rst2_pc", 14'h0000, pc);
    chk_bit("rst2_busy", 1'b0, busy);
    // release again with nothing offered on the first edge
    op_valid = 1'b0;
    rstn = 1'b1;
    @(negedge clk);
    chk_val("rel2_pc", 14'h0000, pc);
    chk_val("rel2_ram", 14'h0000, {4'h0, ram_addr});
    e_pc = 14'h0000;
    e_ram = 10'h000;
    {e_acc, e_b, e_p1, e_p2} = 16'h0000;
    run_op(RAG_OP_RAM_IND, 14'h0000);
    run_op(RAG_OP_TABLE_FETCH, 14'h0003);
    give_verdict();
  end
endmodule : tb_ram_rom_address_generation
`default_nettype wire
